// file: rtl/dbpu_map.svh
// Overview of operation
// - On the 8-pin part the shared pin is plain GPIO unless the key was received while reset was held.
// - After the key the host releases reset and the shared pin then works as the full debug wire.
// - A serial break from the host is accepted even while the debugger is sending a character.
// - A decoded breakpoint opcode 00h from the CPU signals the debugger.
// - With breakpoints and the debug wire enabled, a breakpoint enters debug mode and idles the CPU.
// - With breakpoints disabled, a breakpoint is ignored and acts as a no-operation.
// - After reset release the CPU may run erased code (FFh) yet Flash programming still works.
`ifndef DBPU_MAP_SVH
`define DBPU_MAP_SVH
`define DBPU_CLK_MHZ      100
`define DBPU_SETTLE_MS    5
`define DBPU_SETTLE_CYC   (`DBPU_SETTLE_MS * 1000 * `DBPU_CLK_MHZ)
`define DBPU_AUTOBAUD     8'h80
`define DBPU_AB_LOW_BITS  3
`define DBPU_KEY0         8'heb
`define DBPU_KEY1         8'h5a
`define DBPU_KEY2         8'h70
`define DBPU_KEY3         8'hcd
`define DBPU_KEY_LEN      3'h4
`define DBPU_HALT_CMD     8'h80
`define DBPU_BP_OPCODE    8'h00
`define DBPU_ERASED_OP    8'hff
`define DBPU_BREAK_BITS   4'ha
`endif

// file: rtl/dbpu_pkg.sv
`default_nettype none
package dbpu_pkg;
    typedef enum logic [2:0] {
        RX_AB_IDLE,
        RX_AB_LOW,
        RX_IDLE,
        RX_DATA,
        RX_STOP
    } dbpu_rx_t;
endpackage : dbpu_pkg
`default_nettype wire

// file: rtl/dbpu_top.sv
`include "dbpu_map.svh"
`default_nettype none
module dbpu_top #(
    parameter int CW         = 16,
    parameter int SETTLE_CYC = `DBPU_SETTLE_CYC
) (
    // Clock and block reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Pins
    input  wire logic       shared_gpio_reset_pin_n,
    input  wire logic       debug_wire_in,
    output logic            pad_out,
    output logic            pad_oe,
    // Package strap and port logic
    input  wire logic       package_8pin,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    output logic            debug_pin_enabled,
    // Debugger command side
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            break_seen,
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_data,
    input  wire logic       resume,
    input  wire logic       bp_enable,
    // CPU side
    input  wire logic       op_valid,
    input  wire logic [7:0] opcode,
    output logic            debug_mode,
    output logic            cpu_idle,
    output logic            bp_nop
);
    logic             rp_s1_reg, rp_s2_reg, rp_d_reg;
    logic             dp_s1_reg, dp_s2_reg, dp_d_reg;
    logic [31:0]      settle_reg;
    logic             unlocked_reg;
    logic [2:0]       key_idx_reg;
    dbpu_pkg::dbpu_rx_t rx_state_reg;
    logic [CW-1:0]    cnt_reg, bit_time_reg;
    logic             bit_ok_reg;
    logic [2:0]       bitn_reg;
    logic [7:0]       sh_reg;
    logic [CW+3:0]    low_reg;
    logic             tx_busy_reg;
    logic [9:0]       tx_sh_reg;
    logic [3:0]       tx_n_reg;
    logic [CW-1:0]    tx_cnt_reg;
    logic             rx_done_reg, bp_nop_reg, debug_mode_reg, break_reg;
    logic [7:0]       rx_byte_reg;

    function automatic logic [7:0] key_byte(input logic [2:0] i);
        case (i)
            3'h0:    key_byte = `DBPU_KEY0;
            3'h1:    key_byte = `DBPU_KEY1;
            3'h2:    key_byte = `DBPU_KEY2;
            default: key_byte = `DBPU_KEY3;
        endcase
    endfunction : key_byte

    // Pins cross in from outside: two flops before any use
    always_ff @(posedge clk) begin
        rp_s1_reg <= shared_gpio_reset_pin_n;
        rp_s2_reg <= rp_s1_reg;
        rp_d_reg  <= rp_s2_reg;
        dp_s1_reg <= debug_wire_in;
        dp_s2_reg <= dp_s1_reg;
        dp_d_reg  <= dp_s2_reg;
    end

    logic fall, rise, released, settled, unlocking, listen, bp_hit, tx_low;
    assign fall      = dp_d_reg & ~dp_s2_reg;
    assign rise      = ~dp_d_reg & dp_s2_reg;
    assign released  = rp_s2_reg & ~rp_d_reg;
    assign settled   = settle_reg >= 32'(SETTLE_CYC);
    assign unlocking = package_8pin & ~unlocked_reg & ~rp_s2_reg;
    // While the pin is locked, nothing is taken before the internal reset sequence has had its time
    assign listen    = debug_pin_enabled | (unlocking & settled);
    assign bp_hit    = op_valid & (opcode == `DBPU_BP_OPCODE);
    assign tx_low    = tx_busy_reg & ~tx_sh_reg[0];

    always_ff @(posedge clk) begin
        if (rst || rp_s2_reg) begin
            settle_reg <= 32'h0;
        end else if (!settled) begin
            settle_reg <= settle_reg + 32'h1;
        end
    end

    // Key checker; a wrong byte restarts the match
    always_ff @(posedge clk) begin
        if (rst) begin
            key_idx_reg  <= 3'h0;
            unlocked_reg <= 1'b0;
        end else if (released) begin
            unlocked_reg <= unlocked_reg | (package_8pin && key_idx_reg == `DBPU_KEY_LEN);
            key_idx_reg  <= 3'h0;
        end else if (rx_done_reg && unlocking && key_idx_reg != `DBPU_KEY_LEN) begin
            if (rx_byte_reg == key_byte(key_idx_reg)) begin
                key_idx_reg <= key_idx_reg + 3'h1;
            end else begin
                key_idx_reg <= (rx_byte_reg == `DBPU_KEY0) ? 3'h1 : 3'h0;
            end
        end
    end

    // Receiver with autobaud; 80h holds the line low for start plus seven zero bits
    always_ff @(posedge clk) begin
        rx_done_reg <= 1'b0;
        if (rst || !listen || break_reg || released) begin
            rx_state_reg <= dbpu_pkg::RX_AB_IDLE;
            cnt_reg      <= '0;
            bitn_reg     <= 3'h0;
        end else begin
            case (rx_state_reg)
                dbpu_pkg::RX_AB_IDLE: begin
                    if (fall) begin
                        rx_state_reg <= dbpu_pkg::RX_AB_LOW;
                        cnt_reg      <= CW'(1);
                    end
                end
                dbpu_pkg::RX_AB_LOW: begin
                    if (rise) begin
                        rx_state_reg <= dbpu_pkg::RX_IDLE;
                    end else if (cnt_reg != '1) begin
                        cnt_reg <= cnt_reg + CW'(1);
                    end
                end
                dbpu_pkg::RX_IDLE: begin
                    if (fall) begin
                        rx_state_reg <= dbpu_pkg::RX_DATA;
                        cnt_reg      <= bit_time_reg + (bit_time_reg >> 1);
                        bitn_reg     <= 3'h0;
                    end
                end
                dbpu_pkg::RX_DATA: begin
                    if (cnt_reg <= CW'(1)) begin
                        sh_reg   <= {dp_s2_reg, sh_reg[7:1]};
                        cnt_reg  <= bit_time_reg;
                        bitn_reg <= bitn_reg + 3'h1;
                        if (bitn_reg == 3'h7) begin
                            rx_state_reg <= dbpu_pkg::RX_STOP;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - CW'(1);
                    end
                end
                default: begin
                    if (cnt_reg <= CW'(1)) begin
                        rx_state_reg <= dbpu_pkg::RX_IDLE;
                        rx_done_reg  <= dp_s2_reg;
                        rx_byte_reg  <= sh_reg;
                    end else begin
                        cnt_reg <= cnt_reg - CW'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bit_time_reg <= CW'(1);
            bit_ok_reg   <= 1'b0;
        end else if (rx_state_reg == dbpu_pkg::RX_AB_LOW && rise && listen && !break_reg && !released) begin
            bit_time_reg <= (cnt_reg < CW'(8)) ? CW'(1) : (cnt_reg >> `DBPU_AB_LOW_BITS);
            bit_ok_reg   <= 1'b1;
        end
    end

    // Break: low longer than any character, counted whether or not we drive
    always_ff @(posedge clk) begin
        if (rst || dp_s2_reg || !listen || !bit_ok_reg) begin
            low_reg   <= '0;
            break_reg <= 1'b0;
        end else begin
            if (low_reg != '1) begin
                low_reg <= low_reg + (CW+4)'(1);
            end
            break_reg <= (low_reg == (CW+4)'(bit_time_reg) * (CW+4)'(`DBPU_BREAK_BITS));
        end
    end

    // Transmitter, start bit first, LSB first; a break aborts it
    always_ff @(posedge clk) begin
        if (rst || break_reg || !debug_pin_enabled) begin
            tx_busy_reg <= 1'b0;
            tx_sh_reg   <= 10'h3ff;
            tx_n_reg    <= 4'h0;
            tx_cnt_reg  <= '0;
        end else if (!tx_busy_reg) begin
            if (tx_valid && tx_ready) begin
                tx_busy_reg <= 1'b1;
                tx_sh_reg   <= {1'b1, tx_data, 1'b0};
                tx_n_reg    <= 4'h0;
                tx_cnt_reg  <= bit_time_reg;
            end
        end else if (tx_cnt_reg <= CW'(1)) begin
            tx_cnt_reg <= bit_time_reg;
            tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
            tx_n_reg   <= tx_n_reg + 4'h1;
            tx_busy_reg <= (tx_n_reg != 4'h9);
        end else begin
            tx_cnt_reg <= tx_cnt_reg - CW'(1);
        end
    end

    // Debug mode; a set in the same cycle as resume wins
    always_ff @(posedge clk) begin
        if (rst) begin
            debug_mode_reg <= 1'b0;
            bp_nop_reg     <= 1'b0;
        end else begin
            bp_nop_reg <= bp_hit & ~(bp_enable & debug_pin_enabled);
            if (debug_pin_enabled && ctrl_wr && ctrl_data == `DBPU_HALT_CMD) begin
                debug_mode_reg <= 1'b1;
            end else if (bp_hit && bp_enable && debug_pin_enabled) begin
                debug_mode_reg <= 1'b1;
            end else if (resume) begin
                debug_mode_reg <= 1'b0;
            end
        end
    end

    // Pin mux: open drain only drives low
    assign debug_pin_enabled = ~package_8pin | unlocked_reg;
    assign pad_out    = debug_pin_enabled ? 1'b0 : gpio_out;
    assign pad_oe     = debug_pin_enabled ? tx_low : gpio_oe;
    // Bytes flow to the command logic whatever the CPU runs, so erased code cannot block programming
    assign rx_valid   = rx_done_reg & debug_pin_enabled;
    assign rx_data    = rx_byte_reg;
    assign tx_ready   = ~tx_busy_reg & bit_ok_reg & debug_pin_enabled;
    assign break_seen = break_reg;
    assign debug_mode = debug_mode_reg;
    assign cpu_idle   = debug_mode_reg;
    assign bp_nop     = bp_nop_reg;

    sequence key_done_s;
        package_8pin && !unlocked_reg && key_idx_reg == `DBPU_KEY_LEN && !rp_s2_reg;
    endsequence
    sequence release_s;
        rp_s2_reg && !rp_d_reg;
    endsequence

    chk_gpio_when_locked: assert property (@(posedge clk) disable iff (rst)
        !debug_pin_enabled |-> (pad_out == gpio_out && pad_oe == gpio_oe))
        else $error("shared pin not plain gpio while locked");
    chk_settle_gate: assert property (@(posedge clk) disable iff (rst)
        (!debug_pin_enabled && !settled) |=> rx_state_reg == dbpu_pkg::RX_AB_IDLE)
        else $error("receiver ran before reset settle time");
    chk_key_unlock: assert property (@(posedge clk) disable iff (rst)
        key_done_s ##1 release_s |=> unlocked_reg && debug_pin_enabled)
        else $error("full key did not unlock on reset release");
    chk_wrong_key: assert property (@(posedge clk) disable iff (rst)
        (rx_done_reg && unlocking && !released && key_idx_reg != `DBPU_KEY_LEN
         && rx_byte_reg != key_byte(key_idx_reg)) |=> key_idx_reg <= 3'h1)
        else $error("wrong key byte advanced the match");
    chk_break_abort: assert property (@(posedge clk) disable iff (rst)
        break_reg |=> !tx_busy_reg && (!debug_pin_enabled || !pad_oe))
        else $error("break did not abort transmission");
    chk_bp_enter: assert property (@(posedge clk) disable iff (rst)
        (bp_hit && bp_enable && debug_pin_enabled) |=> (cpu_idle && !bp_nop) ##1 (cpu_idle || $past(resume)))
        else $error("enabled breakpoint did not idle the cpu");
    chk_bp_ignore: assert property (@(posedge clk) disable iff (rst)
        (bp_hit && !bp_enable && !debug_mode_reg && !ctrl_wr) |=> bp_nop && !debug_mode)
        else $error("disabled breakpoint was not a no-op");
    chk_ctrl_enter: assert property (@(posedge clk) disable iff (rst)
        (debug_pin_enabled && ctrl_wr && ctrl_data == `DBPU_HALT_CMD) |=> debug_mode)
        else $error("control write 80h did not enter debug mode");
    chk_autobaud_rate: assert property (@(posedge clk) disable iff (rst)
        (rx_state_reg == dbpu_pkg::RX_AB_LOW && rise && listen && !break_reg && !released && cnt_reg >= CW'(8))
        |=> bit_ok_reg && bit_time_reg == ($past(cnt_reg) >> 3))
        else $error("bit time not one eighth of autobaud low");
    chk_tx_start: assert property (@(posedge clk) disable iff (rst)
        (tx_valid && tx_ready && !break_reg) |=> (pad_oe && tx_busy_reg) [*1] ##1 (tx_busy_reg || $past(break_reg)))
        else $error("transmit start bit not driven");
endmodule : dbpu_top
`default_nettype wire

// file: verif/dbpu_host.sv
`default_nettype none
module dbpu_host #(
    parameter int BT     = 16,
    parameter int SETTLE = 50
) (
    // Clock
    input  wire logic clk,
    // Pins
    input  wire logic wire_level,
    output logic      drive_low,
    output logic      reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        drive_low   = 1'b0;
        reset_pin_n = 1'b1;
    end

    // Only pulls low; the pull-up supplies every 1
    task automatic hold_bit(input logic b, input int n);
        drive_low <= ~b;
        repeat (n) @(negedge clk);
    endtask : hold_bit

    task automatic send_byte(input logic [7:0] b);
        hold_bit(1'b0, BT);
        for (int i = 0; i < 8; i++) hold_bit(b[i], BT);
        hold_bit(1'b1, 2 * BT);
    endtask : send_byte

    // Open drain lets this win over a character in flight
    task automatic send_break();
        hold_bit(1'b0, 12 * BT);
        hold_bit(1'b1, 2 * BT);
    endtask : send_break

    task automatic unlock(input logic [7:0] last);
        reset_pin_n <= 1'b0;
        repeat (SETTLE + 10) @(negedge clk);
        send_byte(8'h80);
        send_byte(8'heb);
        send_byte(8'h5a);
        send_byte(8'h70);
        send_byte(last);
        reset_pin_n <= 1'b1;
        repeat (8) @(negedge clk);
    endtask : unlock

    // Pin reset after unlocking, before system debug starts
    task automatic pulse_reset();
        reset_pin_n <= 1'b0;
        repeat (8) @(negedge clk);
        reset_pin_n <= 1'b1;
        repeat (8) @(negedge clk);
    endtask : pulse_reset

    // Samples mid-bit counted from the start edge
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        for (n = 0; n < 64 && wire_level !== 1'b0; n++) @(negedge clk);
        ok = (n < 64);
        repeat (BT + BT / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = wire_level;
            repeat (BT) @(negedge clk);
        end
    endtask : recv_byte
endmodule : dbpu_host
`default_nettype wire

// file: verif/dbpu_top_test.sv
`default_nettype none
module dbpu_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          BT     = 16;
    localparam int          SETTLE = 50;
    localparam logic [31:0] KEY    = 32'heb5a70cd;
    logic       clk = 1'b0, rst = 1'b1, package_8pin = 1'b1, gpio_out = 1'b0, gpio_oe = 1'b0;
    logic       tx_valid = 1'b0, ctrl_wr = 1'b0, resume = 1'b0, bp_enable = 1'b0, op_valid = 1'b0;
    logic [7:0] tx_data = 8'h00, ctrl_data = 8'h00, opcode = 8'h00, rx_data, got;
    logic       rpin_n, wire_level, host_low, pad_out, pad_oe, debug_pin_enabled, rx_valid;
    logic       tx_ready, break_seen, debug_mode, cpu_idle, bp_nop, ok, exp_mode;
    logic [7:0] sent_q[$];
    int         bad_count = 0;
    int         n_checks  = 0;
    integer     seed      = 32'heed2fe28;

    always #5 clk = ~clk;
    // Pulled-up wire, low while either side pulls it down
    assign wire_level = ~host_low & ~(pad_oe & ~pad_out);

    dbpu_top #(.CW(16), .SETTLE_CYC(SETTLE)) dbpu_top_inst (
        .clk(clk), .rst(rst), .shared_gpio_reset_pin_n(rpin_n), .debug_wire_in(wire_level),
        .pad_out(pad_out), .pad_oe(pad_oe), .package_8pin(package_8pin), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .debug_pin_enabled(debug_pin_enabled), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .break_seen(break_seen),
        .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data), .resume(resume), .bp_enable(bp_enable),
        .op_valid(op_valid), .opcode(opcode), .debug_mode(debug_mode), .cpu_idle(cpu_idle), .bp_nop(bp_nop));
    dbpu_host #(.BT(BT), .SETTLE(SETTLE)) dbpu_host_inst (
        .clk(clk), .wire_level(wire_level), .drive_low(host_low), .reset_pin_n(rpin_n));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    function automatic logic pick(input int which);
        case (which)
            0:       pick = rx_valid;
            1:       pick = tx_ready;
            default: pick = break_seen;
        endcase
    endfunction : pick

    // Polled on falling edges so one-cycle pulses are not missed
    task automatic wait_high(input int which, input string what, input int lim);
        for (int n = 0; n < lim && pick(which) !== 1'b1; n++) @(negedge clk);
        check(what, 8'(pick(which)), 8'h01);
        if (pick(which) !== 1'b1) complete_run();
    endtask : wait_high

    task automatic start_tx(input logic [7:0] d);
        tx_data = d;
        tx_valid = 1'b1;
        wait_high(1, "tx_ready", 64);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask : start_tx

    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        // Larger packages have the debug wire without any unlock
        package_8pin = 1'b0;
        #1;
        check("enabled_big", 8'(debug_pin_enabled), 8'h01);
        package_8pin = 1'b1;
        for (int i = 0; i < 8; i++) begin
            {gpio_out, gpio_oe} = 2'($random(seed));
            #1;
            check("pad_out", 8'(pad_out), 8'(gpio_out));
            check("pad_oe", 8'(pad_oe), 8'(gpio_oe));
            check("enabled", 8'(debug_pin_enabled), 8'h00);
            @(negedge clk);
        end
        gpio_oe = 1'b0;
        $display("test gpio passthrough done");
        // Wrong last key byte first, then the right one
        for (int k = 0; k < 2; k++) begin
            got = k ? 8'hcd : 8'hcd ^ (8'($random(seed)) | 8'h01);
            dbpu_host_inst.unlock(got);
            check("enabled", 8'(debug_pin_enabled), 8'({8'heb, 8'h5a, 8'h70, got} == KEY));
        end
        // A pin reset after unlocking must not lock the pin again
        dbpu_host_inst.pulse_reset();
        check("still_enabled", 8'(debug_pin_enabled), 8'h01);
        $display("test unlock done");
        dbpu_host_inst.send_byte(8'h80);
        got = 8'($random(seed));
        sent_q.push_back(got);
        fork
            dbpu_host_inst.send_byte(got);
            wait_high(0, "rx_valid", 40 * BT);
        join
        check("rx_data", rx_data, sent_q.pop_front());
        sent_q.push_back(8'($random(seed)));
        start_tx(sent_q[0]);
        check("pad_out", 8'(pad_out), 8'h00);
        dbpu_host_inst.recv_byte(got, ok);
        check("tx_start", 8'(ok), 8'h01);
        check("tx_byte", got, sent_q.pop_front());
        start_tx(8'h00);
        repeat (3 * BT) @(negedge clk);
        fork
            dbpu_host_inst.send_break();
            wait_high(2, "break_seen", 40 * BT);
        join
        $display("test serial done");
        for (int i = 0; i < 4; i++) begin
            bp_enable = i[0];
            opcode = i < 2 ? 8'h00 : 8'($random(seed)) | 8'h01;
            exp_mode = bp_enable && opcode == 8'h00;
            op_valid = 1'b1;
            @(negedge clk);
            op_valid = 1'b0;
            check("debug_mode", 8'(debug_mode), 8'(exp_mode));
            check("cpu_idle", 8'(cpu_idle), 8'(exp_mode));
            check("bp_nop", 8'(bp_nop), 8'(!bp_enable && opcode == 8'h00));
            resume = 1'b1;
            @(negedge clk);
            resume = 1'b0;
            check("resumed", 8'(debug_mode), 8'h00);
        end
        ctrl_data = 8'h80;
        ctrl_wr = 1'b1;
        @(negedge clk);
        ctrl_wr = 1'b0;
        check("ctrl_mode", 8'(debug_mode), 8'h01);
        $display("test breakpoint done");
        complete_run();
    end
endmodule : dbpu_top_test
`default_nettype wire
